// File: hdl/rcru_defines.svh
// Purpose: Constants of the reset-cause update block.
// Assumes: Eight-bit cause register 0, two-bit cause register 1.
// Notes:   Field positions for every reset source; status and cause load values for power-on and brown-out only.
`ifndef RCRU_DEFINES_SVH
`define RCRU_DEFINES_SVH
`define RCRU_PC_RESET      15'h0000
`define RCRU_PC_VECTOR     15'h0004
`define RCRU_ST_POR        5'h18
`define RCRU_C0_POR        8'h3c
`define RCRU_C0_BOR_SET    8'h3c
`define RCRU_C0_BOR_MASK   8'h02
`define RCRU_C0_IMPL       8'hff
`define RCRU_C1_IMPL       2'h2
`define RCRU_C1_POR        2'h2
`define RCRU_ST_TO         4
`define RCRU_ST_PD         3
`define RCRU_C0_STKOVF     7
`define RCRU_C0_STKUNF     6
`define RCRU_C0_WIN        5
`define RCRU_C0_WDT        4
`define RCRU_C0_PIN        3
`define RCRU_C0_INSTR      2
`define RCRU_C0_BORF       1
`define RCRU_C0_PORF       0
`define RCRU_C1_MEMORY_VIOLATION_FLAG       1
`define RCRU_STACK_DEPTH   16
`endif

// File: hdl/rcru_pkg.sv
// Purpose: Types of the reset-cause update block.
// Assumes: Nothing beyond the constants header.
// Notes:   Event codes are one-hot free; priority is resolved in the arbiter.
package rcru_pkg;
  typedef enum logic [3:0] {
    RCRU_EV_NONE   = 4'h0,
    RCRU_EV_POR    = 4'h1,
    RCRU_EV_BOR    = 4'h2,
    RCRU_EV_PIN    = 4'h3,
    RCRU_EV_PINSLP = 4'h4,
    RCRU_EV_WDT    = 4'h5,
    RCRU_EV_WIN    = 4'h6,
    RCRU_EV_WDTWK  = 4'h7,
    RCRU_EV_INTWK  = 4'h8,
    RCRU_EV_INSTR  = 4'h9,
    RCRU_EV_OVF    = 4'ha,
    RCRU_EV_UNF    = 4'hb,
    RCRU_EV_MEMORY_VIOLATION_FLAG   = 4'hc
  } rcru_event_t;
  typedef enum logic [1:0] {
    RCRU_S_IDLE  = 2'b00,
    RCRU_S_STEP  = 2'b01,
    RCRU_S_PUSH  = 2'b11
  } rcru_state_t;
endpackage : rcru_pkg

// File: hdl/rcru_src_if.sv
`timescale 1ns/1ps
// Purpose: Carries the chosen reset event from arbiter to core.
// Assumes: Single clock domain.
// Notes:   Valid is a one-cycle pulse.
interface rcru_src_if;
  import rcru_pkg::*;
  logic        valid;
  rcru_event_t ev;
  modport src (output valid, output ev);
  modport dst (input valid, input ev);
endinterface : rcru_src_if

// File: hdl/rcru_arbiter.sv
`timescale 1ns/1ps
// Purpose: Picks one reset event from the simultaneous source pulses.
// Assumes: Source pulses are synchronous, one cycle long.
// Notes:   Power-on beats brown-out beats all others.
module rcru_arbiter
  import rcru_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire logic           ce,
  input  wire logic [11:0]    req,
  rcru_src_if.src             out
);
  typedef struct packed {
    logic        valid;
    rcru_event_t ev;
  } rcru_arb_st_t;
  rcru_arb_st_t s_q;
  rcru_arb_st_t s_d;
  always_comb
  begin
    s_d       = '0;
    s_d.ev    = RCRU_EV_NONE;
    // Lowest request index has the highest priority.
    for (int i = 11; i >= 0; i--)
    begin
      if (req[i])
      begin
        s_d.valid = 1'b1;
        // Request 0 is brown-out, the second event code after none.
        s_d.ev    = rcru_event_t'(4'(i + 2));
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end
  assign out.valid = s_q.valid;
  assign out.ev    = s_q.ev;
endmodule : rcru_arbiter

// File: hdl/rcru_stack_mon.sv
`timescale 1ns/1ps
`include "rcru_defines.svh"
// Purpose: Tracks stack depth and flags overflow and underflow.
// Assumes: Push and pop are one-cycle pulses, never together.
// Notes:   Depth returns to empty on any restart.
module rcru_stack_mon
  import rcru_pkg::*;
#(
  parameter int DEPTH = `RCRU_STACK_DEPTH
)
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic clear,
  input  wire logic push,
  input  wire logic pop,
  output logic      ovf,
  output logic      unf
);
  typedef struct packed {
    logic [4:0] lvl;
  } rcru_stk_st_t;
  rcru_stk_st_t s_q;
  rcru_stk_st_t s_d;
  // The five-bit level counter serves at most sixteen entries.
  if (DEPTH < 1 || DEPTH > 16)
  begin : g_bad_depth
    $error("rcru_stack_mon: DEPTH out of range");
  end
  always_comb
  begin
    s_d = s_q;
    ovf = 1'b0;
    unf = 1'b0;
    if (clear)
      s_d.lvl = '0;
    else if (push)
    begin
      if (s_q.lvl == 5'(DEPTH))
        ovf = 1'b1;
      else
        s_d.lvl = s_q.lvl + 5'h01;
    end
    else if (pop)
    begin
      if (s_q.lvl == 5'h00)
        unf = 1'b1;
      else
        s_d.lvl = s_q.lvl - 5'h01;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else if (ce)
      s_q <= s_d;
  end
endmodule : rcru_stack_mon

// File: hdl/rcru_top.sv
`timescale 1ns/1ps
`include "rcru_defines.svh"
// Purpose: Updates PC, status bits and reset-cause registers per source.
// Assumes: All source pulses are one cycle, synchronous to clk_sys.
// Notes:   Power-on is the asynchronous reset itself.
module rcru_top
  import rcru_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        bor_event,
  input  wire logic        external_reset_pin_event,
  input  wire logic        sleeping,
  input  wire logic        wdt_timeout,
  input  wire logic        wdt_window_violation,
  input  wire logic        interrupt_wake,
  input  wire logic        global_interrupt_enable,
  input  wire logic        reset_instruction,
  input  wire logic        stack_error_reset_enable,
  input  wire logic        stack_push,
  input  wire logic        stack_pop,
  input  wire logic        memory_violation_event,
  input  wire logic [14:0] pc_current,
  output logic [14:0]      pc_load_value,
  output logic             pc_load,
  output logic             ret_push,
  output logic [14:0]      ret_addr,
  output logic [4:0]       status_bits,
  output logic [7:0]       reset_cause_register_0,
  output logic [1:0]       reset_cause_register_1,
  output logic             core_reset
);
  typedef struct packed {
    rcru_state_t st;
    logic [14:0] pc;
    logic        ld;
    logic        push;
    logic [14:0] ret;
    logic [4:0]  stat;
    logic [7:0]  c0;
    logic [1:0]  c1;
    logic        crst;
  } rcru_st_t;

  rcru_st_t    s_q;
  rcru_st_t    s_d;
  logic [1:0]  rsync_q;
  logic        rst_n;
  logic        ovf;
  logic        unf;
  logic [11:0] req;
  rcru_src_if  ev_if ();

  // Reset asserts at once and releases through two flops.
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rsync_q <= 2'b00;
    else
      rsync_q <= {rsync_q[0], 1'b1};
  end
  assign rst_n = rsync_q[1];

  rcru_stack_mon #(.DEPTH(`RCRU_STACK_DEPTH)) u_stk (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .clear   (s_q.crst),
    .push    (stack_push),
    .pop     (stack_pop),
    .ovf     (ovf),
    .unf     (unf)
  );

  // Stack errors reset only while the enable is set.
  always_comb
  begin
    req     = '0;
    req[0]  = bor_event;
    req[1]  = external_reset_pin_event & ~sleeping;
    req[2]  = external_reset_pin_event & sleeping;
    req[3]  = wdt_timeout & ~sleeping;
    req[4]  = wdt_window_violation;
    req[5]  = wdt_timeout & sleeping;
    req[6]  = interrupt_wake & sleeping;
    req[7]  = reset_instruction;
    req[8]  = ovf & stack_error_reset_enable;
    req[9]  = unf & stack_error_reset_enable;
    req[10] = memory_violation_event;
  end

  rcru_arbiter u_arb (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ce      (ce),
    .req     (req),
    .out     (ev_if)
  );

  always_comb
  begin
    s_d      = s_q;
    s_d.ld   = 1'b0;
    s_d.push = 1'b0;
    s_d.crst = 1'b0;
    case (s_q.st)
      RCRU_S_IDLE:
      begin
        if (ev_if.valid)
        begin
          s_d.ld   = 1'b1;
          s_d.pc   = `RCRU_PC_RESET;
          s_d.crst = 1'b1;
          case (ev_if.ev)
            RCRU_EV_BOR:
            begin
              s_d.stat = `RCRU_ST_POR;
              s_d.c0   = `RCRU_C0_BOR_SET |
                         (s_q.c0 & `RCRU_C0_BOR_MASK);
            end
            RCRU_EV_PIN:
              s_d.c0[`RCRU_C0_PIN] = 1'b0;
            RCRU_EV_PINSLP:
            begin
              s_d.stat[`RCRU_ST_TO] = 1'b1;
              s_d.stat[`RCRU_ST_PD] = 1'b0;
              s_d.c0[`RCRU_C0_PIN]  = 1'b0;
            end
            RCRU_EV_WDT:
            begin
              s_d.stat[`RCRU_ST_TO] = 1'b0;
              s_d.c0[`RCRU_C0_WDT]  = 1'b0;
            end
            RCRU_EV_WIN:
              s_d.c0[`RCRU_C0_WIN] = 1'b0;
            RCRU_EV_WDTWK:
            begin
              s_d.crst              = 1'b0;
              s_d.pc                = pc_current + 15'h0001;
              s_d.stat[`RCRU_ST_TO] = 1'b0;
              s_d.stat[`RCRU_ST_PD] = 1'b0;
            end
            RCRU_EV_INTWK:
            begin
              s_d.crst              = 1'b0;
              s_d.pc                = pc_current + 15'h0001;
              s_d.stat[`RCRU_ST_TO] = 1'b1;
              s_d.stat[`RCRU_ST_PD] = 1'b0;
              if (global_interrupt_enable)
              begin
                s_d.ret = pc_current + 15'h0002;
                s_d.st  = RCRU_S_STEP;
              end
            end
            RCRU_EV_INSTR:
              s_d.c0[`RCRU_C0_INSTR] = 1'b0;
            RCRU_EV_OVF:
              s_d.c0[`RCRU_C0_STKOVF] = 1'b1;
            RCRU_EV_UNF:
              s_d.c0[`RCRU_C0_STKUNF] = 1'b1;
            RCRU_EV_MEMORY_VIOLATION_FLAG:
              s_d.c1[`RCRU_C1_MEMORY_VIOLATION_FLAG] = 1'b0;
            default:
              s_d.ld = 1'b0;
          endcase
        end
      end
      // One cycle for the instruction at PC + 1 to run.
      RCRU_S_STEP:
        s_d.st = RCRU_S_PUSH;
      RCRU_S_PUSH:
      begin
        s_d.push = 1'b1;
        s_d.ld   = 1'b1;
        s_d.pc   = `RCRU_PC_VECTOR;
        s_d.st   = RCRU_S_IDLE;
      end
      default:
        s_d.st = RCRU_S_IDLE;
    endcase
    s_d.c0 = s_d.c0 & `RCRU_C0_IMPL;
    s_d.c1 = s_d.c1 & `RCRU_C1_IMPL;
  end

  // Power-on values; bit 0 of cause0 is defined here as zero.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q      <= '0;
      s_q.st   <= RCRU_S_IDLE;
      s_q.pc   <= `RCRU_PC_RESET;
      s_q.stat <= `RCRU_ST_POR;
      s_q.c0   <= `RCRU_C0_POR;
      s_q.c1   <= `RCRU_C1_POR;
      s_q.crst <= 1'b1;
    end
    else if (ce)
      s_q <= s_d;
  end

  assign pc_load_value          = s_q.pc;
  assign pc_load                = s_q.ld;
  assign ret_push               = s_q.push;
  assign ret_addr               = s_q.ret;
  assign status_bits            = s_q.stat;
  assign reset_cause_register_0 = s_q.c0;
  assign reset_cause_register_1 = s_q.c1;
  assign core_reset             = s_q.crst;
endmodule : rcru_top

// File: tb/rcru_top_properties.sv
// Purpose: Concurrent checks on the reset-cause update ports.
// Assumes: Source pulses are one cycle long and come one at a time.
// Notes:   An event check arms only after four cycles with no event or load; AST_UNIMPL checks every cycle.
`timescale 1ns/1ps
module rcru_top_chk
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic        bor_event,
  input wire logic        external_reset_pin_event,
  input wire logic        sleeping,
  input wire logic        wdt_timeout,
  input wire logic        interrupt_wake,
  input wire logic        global_interrupt_enable,
  input wire logic        reset_instruction,
  input wire logic        memory_violation_event,
  input wire logic [14:0] pc_current,
  input wire logic [14:0] pc_load_value,
  input wire logic        pc_load,
  input wire logic        ret_push,
  input wire logic [14:0] ret_addr,
  input wire logic [4:0]  status_bits,
  input wire logic [7:0]  reset_cause_register_0,
  input wire logic [1:0]  reset_cause_register_1,
  input wire logic        core_reset
);
  logic [2:0] gap_q;
  wire  [5:0] evs = {bor_event, external_reset_pin_event, wdt_timeout,
                     interrupt_wake, reset_instruction, memory_violation_event};
  wire        solo = ce && gap_q >= 3'h4 && $onehot(evs);
  wire  [7:0] c0 = reset_cause_register_0;
  wire        rst0 = pc_load && core_reset && pc_load_value == 15'h0;
  // Counts quiet cycles so a check never lands in the dropped window.
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn) gap_q <= 3'h0;
    else if (|evs || pc_load) gap_q <= 3'h0;
    else if (gap_q != 3'h7) gap_q <= gap_q + 3'h1;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_wake;
    ##2 pc_load && !core_reset && pc_load_value == $past(pc_current, 2) + 15'h1;
  endsequence
  sequence s_vector;
    pc_load && ret_push && pc_load_value == 15'h0004
      && ret_addr == $past(pc_current, 4) + 15'h2;
  endsequence
  AST_BOR: assert property (solo && bor_event |-> ##2 rst0
    && status_bits == 5'h18 && c0[7:2] == 6'h0f && !c0[0]) else $error("bor");
  AST_PIN_RUN: assert property (solo && external_reset_pin_event && !sleeping
    |-> ##2 rst0 && c0 == ($past(c0, 2) & 8'hf7)) else $error("pin run");
  AST_PIN_SLP: assert property (solo && external_reset_pin_event && sleeping
    |-> ##2 rst0 && status_bits == 5'h10 && !c0[3]) else $error("pin sleep");
  AST_WDT_WAKE: assert property (solo && wdt_timeout && sleeping
    |-> s_wake ##0 status_bits[4:3] == 2'b00) else $error("wdt wake");
  AST_INT_WAKE: assert property (solo && interrupt_wake && sleeping
    |-> s_wake ##0 status_bits[4:3] == 2'b10 && c0 == $past(c0, 2))
    else $error("int wake");
  AST_VECTOR: assert property (solo && interrupt_wake && sleeping
    && global_interrupt_enable |-> s_wake ##2 s_vector) else $error("vector");
  AST_INSTR: assert property (solo && reset_instruction |-> ##2 rst0
    && c0 == ($past(c0, 2) & 8'hfb)) else $error("instruction");
  AST_MEMORY_VIOLATION_FLAG: assert property (solo && memory_violation_event |-> ##2 rst0
    && !reset_cause_register_1[1] && c0 == $past(c0, 2)) else $error("memory_violation_flag");
  AST_UNIMPL: assert property (status_bits[2:0] == 3'h0
    && !reset_cause_register_1[0]) else $error("unimplemented bits set");
endmodule : rcru_top_chk
bind rcru_top rcru_top_chk u_chk (.*);

// File: tb/rcru_top_tb_top.sv
// Purpose: Self-checking bench of the reset-cause update block.
// Assumes: Events are fired one at a time, ten cycles apart.
// Notes:   Expected images are queued and popped on every pc_load.
`timescale 1ns/1ps
module rcru_top_tb_top;
  import rcru_pkg::*;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic        sleeping = 1'b0;
  logic        global_interrupt_enable = 1'b0;
  logic        stack_error_reset_enable = 1'b0;
  logic [14:0] pc_current = 15'h0;
  logic [8:0]  ev = 9'h0;
  wire         bor_event = ev[0];
  wire         external_reset_pin_event = ev[1];
  wire         wdt_timeout = ev[2];
  wire         wdt_window_violation = ev[3];
  wire         interrupt_wake = ev[4];
  wire         reset_instruction = ev[5];
  wire         memory_violation_event = ev[6];
  wire         stack_push = ev[7];
  wire         stack_pop = ev[8];
  logic [14:0] pc_load_value, ret_addr;
  logic [4:0]  status_bits, st;
  logic [7:0]  reset_cause_register_0, c0;
  logic [1:0]  reset_cause_register_1, c1;
  logic        pc_load, ret_push, core_reset, wake, err;
  logic [31:0] rnd = 32'h25;
  logic [44:0] q[$];
  logic [44:0] nt;
  int          dep = 0;
  int          n_errors = 0;
  int          n_compared = 0;

  rcru_top uut (.*);

  always #25 clk_sys = ~clk_sys;

  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction : xs

  task automatic chk(input string nm, input logic [29:0] e, a);
    n_compared++;
    if (a !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, a);
    end
  endtask : chk

  task automatic note(input logic [14:0] pc, ra);
    q.push_back({pc, st, c0, c1, ra});
    if (pc == 15'h0) dep = 0;
  endtask : note

  // Updates the expected images, then pulses source k for one cycle.
  task automatic fire(input int k, input logic slp);
    sleeping = slp;
    pc_current = 15'(xs() & 32'h3fff);
    wake = (k == 2 || k == 4) && slp;
    case (k)
      0: {st, c0} = {5'h18, 6'h0f, c0[1], 1'b0};
      1: {st, c0[3]} = {slp ? 5'h10 : st, 1'b0};
      2: {st[4:3], c0[4]} = {slp ? 2'b00 : {1'b0, st[3]}, slp & c0[4]};
      3: c0[5] = 1'b0;
      4: st[4:3] = slp ? 2'b10 : st[4:3];
      5: c0[2] = 1'b0;
      6: c1[1] = 1'b0;
      7: dep++;
      default: dep--;
    endcase
    err = (dep > 16 || dep < 0) && stack_error_reset_enable;
    if (err) c0[14 - k] = 1'b1;
    if (dep < 0) dep = 0;
    if (wake) note(pc_current + 15'h1, 15'h0);
    if (wake && k == 4 && global_interrupt_enable)
      note(15'h4, pc_current + 15'h2);
    if ((k < 7 && k != 4 && !wake) || err) note(15'h0, 15'h0);
    ev[k] = 1'b1;
    @(negedge clk_sys);
    ev = 9'h0;
    repeat (9) @(negedge clk_sys);
  endtask : fire

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  always @(negedge clk_sys)
  begin
    if (resetn && pc_load !== 1'b0)
    begin
      if (q.size() == 0)
        chk("unexpected load", 30'h0, 30'h1);
      else
      begin
        nt = q.pop_front();
        chk("image", nt[44:15], {pc_load_value, status_bits,
          reset_cause_register_0, reset_cause_register_1});
        chk("restart", {13'h0, nt[44:30] == 15'h0, nt[14:0] != 15'h0,
          nt[14:0]}, {13'h0, core_reset, ret_push, ret_addr & {15{ret_push}}});
      end
    end
  end

  initial
  begin
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    {st, c0, c1} = {5'h18, 8'h3c, 2'h2};
    chk("power-on", {15'h0, st, c0, c1}, {pc_load_value, status_bits,
      reset_cause_register_0, reset_cause_register_1});
    $display("test power-on done");
    fire(2, 1'b0);
    fire(4, 1'b1);
    fire(3, 1'b0);
    fire(2, 1'b1);
    fire(1, 1'b1);
    fire(1, 1'b0);
    fire(5, 1'b0);
    fire(6, 1'b0);
    fire(4, 1'b0);
    global_interrupt_enable = 1'b1;
    fire(4, 1'b1);
    fire(0, 1'b0);
    $display("test sources done");
    stack_error_reset_enable = 1'b1;
    repeat (17) fire(7, 1'b0);
    fire(8, 1'b0);
    stack_error_reset_enable = 1'b0;
    fire(8, 1'b0);
    $display("test stack done");
    repeat (30)
    begin
      global_interrupt_enable = 1'(xs());
      fire(int'(xs() % 7), 1'(xs()));
    end
    $display("test random done");
    chk("pending", 30'h0, 30'(q.size()));
    wrap_up();
  end

  initial
  begin
    #(2000 * 50);
    n_errors++;
    wrap_up();
  end
endmodule : rcru_top_tb_top
